// *** rtl/iar_pkg.sv ***
// ****************************************************************
// Constants and types of the I2C alias remap table.
// ****************************************************************
package iar_pkg;

  // Number of entries of each kind held in this block.
  localparam int NUM_ENTRIES = 3;

  // Width of an I2C target address and of a table register.
  localparam int ADDR_W = 7;
  localparam int REG_W  = 8;

  // Offsets of the remote target address entries 5 to 7.
  localparam logic [7:0] OFF_REMOTE_TARGET_ADDR_5 = 8'h74;
  localparam logic [7:0] OFF_REMOTE_TARGET_ADDR_6 = 8'h75;
  localparam logic [7:0] OFF_REMOTE_TARGET_ADDR_7 = 8'h76;

  // Offsets of the local alias entries 1 to 3.
  localparam logic [7:0] OFF_LOCAL_ALIAS_ADDR_1 = 8'h77;
  localparam logic [7:0] OFF_LOCAL_ALIAS_ADDR_2 = 8'h78;
  localparam logic [7:0] OFF_LOCAL_ALIAS_ADDR_3 = 8'h79;

  // Field position of the address inside a table register.
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // Value after reset of every entry, which means disabled.
  localparam logic [6:0] ENTRY_RESET = 7'h00;

  // Address value that disables an entry.
  localparam logic [6:0] ENTRY_OFF = 7'h00;

  // Entry numbers of the first alias and the first remote target here.
  localparam logic [2:0] IDX_ALIAS_BASE  = 3'h1;
  localparam logic [2:0] IDX_TARGET_BASE = 3'h5;

  // Three seven-bit addresses, element k is entry base plus k.
  typedef logic [2:0][6:0] iar_addr3_t;

  // One transaction handed to the control channel.
  typedef struct packed {
    logic       port;
    logic [2:0] index;
    logic [6:0] addr;
  } iar_fwd_t;

  // Sys side lookup state machine.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } iar_state_t;

endpackage : iar_pkg

// *** rtl/iar_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two flip-flop level synchroniser.
// ****************************************************************
module iar_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic d,
  output var  logic q
);

  logic meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : iar_sync

`default_nettype wire

// *** rtl/iar_link.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Control channel side of the remap table, on the link clock.
// ****************************************************************
module iar_link (
  input  wire logic              link_clk,
  input  wire logic              rstn,
  input  wire logic              req_tgl,
  input  wire iar_pkg::iar_fwd_t fwd_in,
  input  wire logic              fwd_ready,
  output var  logic              fwd_valid_reg,
  output var  iar_pkg::iar_fwd_t fwd_out_reg,
  output var  logic              ack_tgl_reg
);

  logic req_sync;
  logic seen_reg;
  wire  new_req = (req_sync != seen_reg) && !fwd_valid_reg;
  wire  taken   = fwd_valid_reg && fwd_ready;

  // Request toggle from the system clock domain.
  iar_sync u_req_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    (req_tgl),
    .q    (req_sync)
  );

  // The sys side holds fwd_in still until the acknowledge returns,
  // so the word is safe to sample once the toggle has arrived.
  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_reg      <= 1'b0;
      fwd_valid_reg <= 1'b0;
      fwd_out_reg   <= '0;
      ack_tgl_reg   <= 1'b0;
    end
    else
    begin
      if (new_req)
      begin
        seen_reg      <= req_sync;
        fwd_valid_reg <= 1'b1;
        fwd_out_reg   <= fwd_in;
      end
      else if (taken)
      begin
        fwd_valid_reg <= 1'b0;
        ack_tgl_reg   <= ~ack_tgl_reg;
      end
    end
  end

endmodule : iar_link

`default_nettype wire

// *** rtl/iar_alias_table.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// I2C alias remap table: storage, register port and lookup.
// ****************************************************************

// What this block does
// - Target entry holds seven-bit address in bits 7:1.
// - Matched alias forwards with remote target address.
// - Zero target address disables that entry.
// - Alias entry holds seven-bit alias in bits 7:1.
// - Alias N remaps to target entry N.
// - Zero alias never matches.
// - Second port select steers register access copy.
module iar_alias_table #(
  parameter int NUM_ENTRIES = iar_pkg::NUM_ENTRIES
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                link_clk,
  input  wire logic                second_port_select,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output var  logic [7:0]          reg_rdata_reg,
  input  wire iar_pkg::iar_addr3_t ext_target_lo_p0,
  input  wire iar_pkg::iar_addr3_t ext_target_lo_p1,
  input  wire iar_pkg::iar_addr3_t ext_alias_hi_p0,
  input  wire iar_pkg::iar_addr3_t ext_alias_hi_p1,
  input  wire logic                lk_req,
  input  wire logic [6:0]          lk_alias,
  input  wire logic                lk_port,
  output var  logic                lk_done_reg,
  output var  logic                lk_hit_reg,
  output var  logic                lk_refused_reg,
  output var  logic [2:0]          lk_index_reg,
  output var  logic                lk_busy_reg,
  input  wire logic                fwd_ready,
  output var  logic                fwd_valid_reg,
  output var  iar_pkg::iar_fwd_t   fwd_out_reg
);

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************

  // The offset decode below serves exactly three entries per kind.
  if (NUM_ENTRIES != iar_pkg::NUM_ENTRIES)
  begin : g_bad_entries
    $error("iar_alias_table supports exactly three entries per kind.");
  end

  // The field position must cover exactly one seven-bit address.
  if (iar_pkg::ADDR_MSB - iar_pkg::ADDR_LSB + 1 != iar_pkg::ADDR_W)
  begin : g_bad_field
    $error("iar_alias_table needs a seven-bit address field.");
  end

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Extracts the address field of a written register byte.
  function automatic logic [6:0] field_of(input logic [7:0] b);
    field_of = b[iar_pkg::ADDR_MSB:iar_pkg::ADDR_LSB];
  endfunction : field_of

  // Forms the read byte of an entry; the reserved bit reads zero.
  function automatic logic [7:0] byte_of(input logic [6:0] a);
    byte_of = {a, 1'b0};
  endfunction : byte_of

  // True when an entry is live for the given alias and leads on.
  function automatic logic entry_hits(input logic [6:0] alias_a,
                                      input logic [6:0] target_a,
                                      input logic [6:0] want);
    entry_hits = (alias_a != iar_pkg::ENTRY_OFF) &&
                 (alias_a == want) &&
                 (target_a != iar_pkg::ENTRY_OFF);
  endfunction : entry_hits

  // ****************************************************************
  // Table storage and register port.
  // ****************************************************************

  // Two copies of each entry, one for each link port.
  logic [6:0] target_reg [2][3];
  logic [6:0] alias_reg  [2][3];

  // Copy that the register port reaches.
  wire        reg_copy = second_port_select;

  // Offset decode of the six table registers.
  wire [2:0] hit_target;
  wire [2:0] hit_alias;
  assign hit_target[0] = (reg_addr == iar_pkg::OFF_REMOTE_TARGET_ADDR_5);
  assign hit_target[1] = (reg_addr == iar_pkg::OFF_REMOTE_TARGET_ADDR_6);
  assign hit_target[2] = (reg_addr == iar_pkg::OFF_REMOTE_TARGET_ADDR_7);
  assign hit_alias[0]  = (reg_addr == iar_pkg::OFF_LOCAL_ALIAS_ADDR_1);
  assign hit_alias[1]  = (reg_addr == iar_pkg::OFF_LOCAL_ALIAS_ADDR_2);
  assign hit_alias[2]  = (reg_addr == iar_pkg::OFF_LOCAL_ALIAS_ADDR_3);

  // Written field; bit 0 of the byte is dropped.
  wire [6:0] wr_field = field_of(reg_wdata);

  // Writes store bits 7:1 into the selected port's copy.
  // A lookup in the same cycle still sees the old entry.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int k = 0; k < 3; k++)
        begin
          target_reg[p][k] <= iar_pkg::ENTRY_RESET;
          alias_reg[p][k]  <= iar_pkg::ENTRY_RESET;
        end
      end
    end
    else if (reg_wr)
    begin
      for (int k = 0; k < 3; k++)
      begin
        if (hit_target[k])
          target_reg[reg_copy][k] <= wr_field;
        if (hit_alias[k])
          alias_reg[reg_copy][k] <= wr_field;
      end
    end
  end

  // Read mux; offsets outside the table read zero.
  logic [7:0] rd_next;
  always_comb
  begin
    rd_next = '0;
    for (int k = 0; k < 3; k++)
    begin
      if (hit_target[k])
        rd_next = byte_of(target_reg[reg_copy][k]);
      if (hit_alias[k])
        rd_next = byte_of(alias_reg[reg_copy][k]);
    end
  end

  // Read data follows the address one clock later.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_reg <= '0;
    else
      reg_rdata_reg <= rd_next;
  end

  // ****************************************************************
  // Alias lookup.
  // ****************************************************************

  // Entries of the port that the transaction is routed to.
  iar_pkg::iar_addr3_t lo_target;
  iar_pkg::iar_addr3_t hi_alias;
  assign lo_target = lk_port ? ext_target_lo_p1 : ext_target_lo_p0;
  assign hi_alias  = lk_port ? ext_alias_hi_p1 : ext_alias_hi_p0;

  // Lowest matching entry number wins; later loop passes override.
  logic       m_hit;
  logic [2:0] m_index;
  logic [6:0] m_addr;
  always_comb
  begin
    m_hit   = 1'b0;
    m_index = '0;
    m_addr  = '0;
    for (int k = 2; k >= 0; k--)
    begin
      // Entries 5 to 7: alias outside, remote target held here.
      if (entry_hits(hi_alias[k], target_reg[lk_port][k], lk_alias))
      begin
        m_hit   = 1'b1;
        m_index = iar_pkg::IDX_TARGET_BASE + 3'(k);
        m_addr  = target_reg[lk_port][k];
      end
    end
    for (int k = 2; k >= 0; k--)
    begin
      // Entries 1 to 3: alias held here, remote target outside.
      if (entry_hits(alias_reg[lk_port][k], lo_target[k], lk_alias))
      begin
        m_hit   = 1'b1;
        m_index = iar_pkg::IDX_ALIAS_BASE + 3'(k);
        m_addr  = lo_target[k];
      end
    end
  end

  // ****************************************************************
  // Hand-off to the control channel.
  // ****************************************************************

  iar_pkg::iar_state_t state_reg;
  iar_pkg::iar_state_t state_next;
  iar_pkg::iar_fwd_t   hold_reg;
  logic                req_tgl_reg;
  logic                ack_tgl_link;
  logic                ack_sync;
  logic                ack_seen_reg;

  // A returned acknowledge frees the hold register.
  wire ack_new  = (ack_sync != ack_seen_reg);
  wire idle     = (state_reg == iar_pkg::ST_IDLE);
  wire launch   = lk_req && idle && m_hit;

  // Busy while one forward is on its way over the channel.
  always_comb
  begin
    case (state_reg)
      iar_pkg::ST_IDLE:
        state_next = launch ? iar_pkg::ST_BUSY : iar_pkg::ST_IDLE;
      iar_pkg::ST_BUSY:
        state_next = ack_new ? iar_pkg::ST_IDLE : iar_pkg::ST_BUSY;
      default:
        state_next = iar_pkg::ST_IDLE;
    endcase
  end

  // State, request toggle and the held forward word. The word stays
  // still from launch until the acknowledge returns, which lets the link
  // side sample it without a second handshake.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg    <= iar_pkg::ST_IDLE;
      hold_reg     <= '0;
      req_tgl_reg  <= 1'b0;
      ack_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      ack_seen_reg <= ack_sync;
      if (launch)
      begin
        hold_reg    <= '{port: lk_port, index: m_index, addr: m_addr};
        req_tgl_reg <= ~req_tgl_reg;
      end
    end
  end

  // Lookup answer, one clock after the request. A request that meets a
  // busy hand-off is answered but refused, so the caller always gets
  // exactly one done pulse per request.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      lk_done_reg    <= 1'b0;
      lk_hit_reg     <= 1'b0;
      lk_refused_reg <= 1'b0;
      lk_index_reg   <= '0;
      lk_busy_reg    <= 1'b0;
    end
    else
    begin
      lk_done_reg    <= lk_req;
      lk_hit_reg     <= launch;
      lk_refused_reg <= lk_req && !idle;
      lk_index_reg   <= launch ? m_index : 3'h0;
      lk_busy_reg    <= (state_next == iar_pkg::ST_BUSY);
    end
  end

  // ****************************************************************
  // Clock domain crossing.
  // ****************************************************************

  // Acknowledge toggle back from the link clock domain.
  iar_sync u_ack_sync (
    .clk  (clk_sys),
    .rstn (rstn),
    .d    (ack_tgl_link),
    .q    (ack_sync)
  );

  // Link clock side of the channel hand-off.
  iar_link u_link (
    .link_clk      (link_clk),
    .rstn          (rstn),
    .req_tgl       (req_tgl_reg),
    .fwd_in        (hold_reg),
    .fwd_ready     (fwd_ready),
    .fwd_valid_reg (fwd_valid_reg),
    .fwd_out_reg   (fwd_out_reg),
    .ack_tgl_reg   (ack_tgl_link)
  );

endmodule : iar_alias_table

`default_nettype wire

// *** verification/iar_alias_table_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checks of the alias remap table.
// ****************************************************************
module iar_alias_table_asserts #(
  parameter int NUM_ENTRIES = 3
) (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              link_clk,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_rdata_reg,
  input wire logic              lk_req,
  input wire logic [6:0]        lk_alias,
  input wire logic              lk_done_reg,
  input wire logic              lk_hit_reg,
  input wire logic              lk_refused_reg,
  input wire logic [2:0]        lk_index_reg,
  input wire logic              lk_busy_reg,
  input wire logic              fwd_ready,
  input wire logic              fwd_valid_reg,
  input wire iar_pkg::iar_fwd_t fwd_out_reg
);
  // High while the offset names one of the six table registers.
  wire logic mapped = (reg_addr >= 8'h74) && (reg_addr <= 8'h79);

  done_next_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_req |=> lk_done_reg)
    else $error("lookup not answered");
  busy_refuse_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_req && lk_busy_reg |=> lk_refused_reg && !lk_hit_reg)
    else $error("busy lookup not refused");
  hit_busy_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_hit_reg |-> lk_done_reg && lk_busy_reg && !lk_refused_reg)
    else $error("hit without busy");
  zero_alias_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_req && lk_alias == 7'h00 |=> !lk_hit_reg)
    else $error("zero alias hit");
  index_legal_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_done_reg |-> (lk_hit_reg ? lk_index_reg inside {3'h1, 3'h2, 3'h3,
    3'h5, 3'h6, 3'h7} : lk_index_reg == 3'h0))
    else $error("bad index");
  rsv_bit_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    reg_rdata_reg[0] == 1'b0)
    else $error("reserved bit set");
  unmapped_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !mapped |=> reg_rdata_reg == 8'h00)
    else $error("unmapped read not zero");
  fwd_soon_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    lk_hit_reg |-> ##[1:24] fwd_valid_reg)
    else $error("forward late");
  fwd_hold_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    fwd_valid_reg && !fwd_ready |=> fwd_valid_reg && $stable(fwd_out_reg))
    else $error("forward changed while stalled");
  fwd_drop_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    fwd_valid_reg && fwd_ready |=> !fwd_valid_reg)
    else $error("valid kept");
  fwd_target_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    fwd_valid_reg |-> fwd_out_reg.addr != 7'h00 &&
    fwd_out_reg.index inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7})
    else $error("disabled target forwarded");

  hit_c: cover property (@(posedge clk_sys) lk_hit_reg);
  refuse_c: cover property (@(posedge clk_sys) lk_refused_reg);
  stall_c: cover property (@(posedge link_clk) fwd_valid_reg && !fwd_ready);
endmodule : iar_alias_table_asserts

bind iar_alias_table iar_alias_table_asserts
  #(.NUM_ENTRIES(NUM_ENTRIES)) u_chk (
  .clk_sys, .rstn, .link_clk, .reg_addr, .reg_rdata_reg, .lk_req, .lk_alias,
  .lk_done_reg, .lk_hit_reg, .lk_refused_reg, .lk_index_reg, .lk_busy_reg,
  .fwd_ready, .fwd_valid_reg, .fwd_out_reg);
`default_nettype wire

// *** verification/iar_chan_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Control channel far end: takes forwards promptly or slowly.
// ****************************************************************
module iar_chan_model (
  input  wire logic              link_clk,
  input  wire logic              rstn,
  input  wire logic              slow,
  input  wire logic              fwd_valid_reg,
  input  wire iar_pkg::iar_fwd_t fwd_out_reg,
  output var  logic              fwd_ready,
  output var  iar_pkg::iar_fwd_t got,
  output var  int                n_got
);
  logic [1:0] wait_cnt;

  // In slow mode the channel stalls three link cycles before taking.
  assign fwd_ready = fwd_valid_reg && (!slow || wait_cnt == 2'h3);

  // Counts the stall and keeps the last forward taken.
  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_cnt <= 2'h0;
      got <= '0;
      n_got <= 0;
    end
    else if (fwd_valid_reg && fwd_ready)
    begin
      wait_cnt <= 2'h0;
      got <= fwd_out_reg;
      n_got <= n_got + 1;
    end
    else if (fwd_valid_reg)
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule : iar_chan_model
`default_nettype wire

// *** verification/iar_alias_table_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Testbench of the alias remap table.
// ****************************************************************
module iar_alias_table_tb_top;
  logic                clk_sys = 1'b0;
  logic                link_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                second_port_select = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic                reg_wr = 1'b0;
  logic [7:0]          reg_wdata = 8'h00;
  logic [7:0]          reg_rdata_reg;
  iar_pkg::iar_addr3_t ext_target_lo_p0 = {7'h33, 7'h00, 7'h50};
  iar_pkg::iar_addr3_t ext_target_lo_p1 = {7'h00, 7'h00, 7'h61};
  iar_pkg::iar_addr3_t ext_alias_hi_p0 = {7'h00, 7'h23, 7'h00};
  iar_pkg::iar_addr3_t ext_alias_hi_p1 = {7'h00, 7'h00, 7'h00};
  logic                lk_req = 1'b0;
  logic [6:0]          lk_alias = 7'h00;
  logic                lk_port = 1'b0;
  logic                slow = 1'b0;
  logic                lk_done_reg, lk_hit_reg, lk_refused_reg, lk_busy_reg;
  logic                fwd_ready, fwd_valid_reg;
  logic [2:0]          lk_index_reg;
  iar_pkg::iar_fwd_t   fwd_out_reg, got;
  int                  n_got, i;
  int                  errors = 0;
  int                  n_tests = 0;
  int                  cycles = 0;
  logic [7:0]          wr_val [6] = '{8'h5B, 8'h8D, 8'h11,
                                      8'h43, 8'h31, 8'hFF};

  iar_alias_table DUT (.clk_sys, .rstn, .link_clk, .second_port_select,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata_reg, .ext_target_lo_p0,
    .ext_target_lo_p1, .ext_alias_hi_p0, .ext_alias_hi_p1, .lk_req, .lk_alias,
    .lk_port, .lk_done_reg, .lk_hit_reg, .lk_refused_reg, .lk_index_reg,
    .lk_busy_reg, .fwd_ready, .fwd_valid_reg, .fwd_out_reg);
  iar_chan_model u_chan (.link_clk, .rstn, .slow, .fwd_valid_reg, .fwd_out_reg,
    .fwd_ready, .got, .n_got);

  // Clocks of the two domains, unrelated in phase.
  initial forever #12.5 clk_sys = ~clk_sys;
  initial
  begin
    #7;
    forever #40 link_clk = ~link_clk;
  end

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    check("rdata", {8'h00, reg_rdata_reg}, {8'h00, exp});
  endtask : rd_chk

  // One lookup; a hit is followed to the channel, refuse adds a busy try.
  task automatic lookup(logic port, logic [6:0] al, logic hit,
                        logic [2:0] idx, logic [6:0] ad, logic refuse);
    int k;
    int w;
    logic [15:0] ans;
    k = n_got;
    @(negedge clk_sys);
    lk_port = port;
    lk_alias = al;
    lk_req = 1'b1;
    @(negedge clk_sys);
    lk_req = 1'b0;
    ans = 16'({lk_done_reg, lk_hit_reg, lk_refused_reg, lk_index_reg});
    check("lookup", ans, 16'({1'b1, hit, 1'b0, idx}));
    if (refuse)
    begin
      @(negedge clk_sys);
      lk_req = 1'b1;
      @(negedge clk_sys);
      lk_req = 1'b0;
      // Done, no hit, refused, and the first forward still in flight.
      ans = 16'({lk_done_reg, lk_hit_reg, lk_refused_reg, lk_busy_reg});
      check("refused", ans, 16'h000B);
    end
    for (w = 0; w < 400 && hit && n_got == k; w++)
      @(negedge clk_sys);
    for (w = 0; w < 400 && lk_busy_reg !== 1'b0; w++)
      @(negedge clk_sys);
    // A wait that ran out leaves busy high and counts as a mismatch.
    check("idle", 16'(lk_busy_reg), 16'h0000);
    check("forwards", 16'(n_got - k), 16'(hit));
    if (hit)
      check("fwd", 16'(got), 16'({port, idx, ad}));
  endtask : lookup

  // Cuts a hang short.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    for (i = 0; i < 6; i++)
      rd_chk(8'h74 + i[7:0], 8'h00);
    for (i = 0; i < 6; i++)
      reg_write(8'h74 + i[7:0], wr_val[i]);
    for (i = 0; i < 6; i++)
      rd_chk(8'h74 + i[7:0], wr_val[i] & 8'hFE);
    reg_write(8'h73, 8'hAA);
    reg_write(8'h7A, 8'hAA);
    rd_chk(8'h73, 8'h00);
    rd_chk(8'h7A, 8'h00);
    second_port_select = 1'b1;
    rd_chk(8'h77, 8'h00);
    reg_write(8'h77, 8'h2B);
    rd_chk(8'h77, 8'h2A);
    second_port_select = 1'b0;
    rd_chk(8'h77, 8'h42);
    lookup(1'b0, 7'h21, 1'b1, 3'h1, 7'h50, 1'b0);
    slow = 1'b1;
    lookup(1'b0, 7'h23, 1'b1, 3'h6, 7'h46, 1'b0);
    slow = 1'b0;
    lookup(1'b0, 7'h18, 1'b0, 3'h0, 7'h00, 1'b0);
    lookup(1'b0, 7'h7F, 1'b1, 3'h3, 7'h33, 1'b1);
    lookup(1'b1, 7'h15, 1'b1, 3'h1, 7'h61, 1'b0);
    lookup(1'b0, 7'h15, 1'b0, 3'h0, 7'h00, 1'b0);
    lookup(1'b0, 7'h00, 1'b0, 3'h0, 7'h00, 1'b0);
    print_verdict();
  end
endmodule : iar_alias_table_tb_top
`default_nettype wire
